//--- logic/eac_pkg.sv
`default_nettype none
package eac_pkg;

  // eeprom geometry
  localparam int EAC_ADDR_W = 11;
  localparam int EAC_DATA_W = 8;
  localparam int EAC_DEPTH = 2048;

  // i/o space offsets (6-bit i/o address)
  localparam int EAC_IO_ADDR_W = 6;
  localparam logic [5:0] EAC_OFS_CONTROL = 6'h1F;
  localparam logic [5:0] EAC_OFS_DATA = 6'h20;
  localparam logic [5:0] EAC_OFS_ADDR_LO = 6'h21;
  localparam logic [5:0] EAC_OFS_ADDR_HI = 6'h22;

  // control register bit positions
  localparam int EAC_BIT_READ_STROBE = 0;
  localparam int EAC_BIT_WRITE_STROBE = 1;
  localparam int EAC_BIT_MASTER_WRITE_ARM = 2;
  localparam int EAC_BIT_READY_IRQ_ENABLE = 3;
  localparam logic [3:0] EAC_CTRL_RSVD_VAL = 4'h0;

  // reset values
  localparam logic [7:0] EAC_DATA_RST = 8'h00;
  localparam logic [10:0] EAC_ADDR_RST = 11'h000;
  localparam logic [7:0] EAC_RDATA_RST = 8'h00;

  // cpu-side cycle counts
  localparam int EAC_ARM_CYCLES = 4;
  localparam int EAC_WR_STALL_CYCLES = 2;
  localparam int EAC_RD_STALL_CYCLES = 4;
  localparam int EAC_CNT_W = 3;

  // clock rates and write timing
  localparam int EAC_CLK_KHZ = 40000;
  localparam int EAC_RC_KHZ = 8000;
  localparam int EAC_RC_DIV = (EAC_CLK_KHZ + EAC_RC_KHZ - 1) / EAC_RC_KHZ;
  localparam int EAC_WRITE_RC_CYCLES = 27072;
  localparam int EAC_WRITE_TIME_US = 3400;
  localparam int EAC_TMR_W = 16;

  // write sequencer states
  typedef enum logic [1:0] {
    EAC_WR_IDLE,
    EAC_WR_BUSY,
    EAC_WR_COMMIT
  } eac_wr_state_t;

endpackage
`default_nettype wire

//--- logic/eac_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eac_core_if;
  import eac_pkg::*;
  logic [EAC_ADDR_W-1:0] mem_addr;
  logic [EAC_DATA_W-1:0] mem_wdata;
  logic [EAC_DATA_W-1:0] mem_rdata;
  logic mem_we;
  logic mem_re;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;

  modport ctrl (
    output mem_addr, mem_wdata, mem_we, mem_re, tmr_start,
    input mem_rdata, tmr_busy, tmr_done
  );
  modport mem (
    input mem_addr, mem_wdata, mem_we, mem_re,
    output mem_rdata
  );
  modport tmr (
    input tmr_start,
    output tmr_busy, tmr_done
  );
endinterface
`default_nettype wire

//--- logic/eac_store.sv
`timescale 1ns/1ps
`default_nettype none
module eac_store (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // core side
  eac_core_if.mem core
);
  import eac_pkg::*;

  // cell array; no reset, contents survive like nonvolatile cells
  logic [EAC_DATA_W-1:0] cells [EAC_DEPTH];
  logic [EAC_DATA_W-1:0] rdata_q;

  // byte commit at the end of a timed write
  always_ff @(posedge clk) begin
    if (core.mem_we) begin
      cells[core.mem_addr] <= core.mem_wdata;
    end
  end

  // registered fetch, ready one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= EAC_RDATA_RST;
    end else if (core.mem_re) begin
      rdata_q <= cells[core.mem_addr];
    end
  end

  assign core.mem_rdata = rdata_q;
endmodule
`default_nettype wire

//--- logic/eac_write_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eac_write_timer #(
  parameter int RC_CYCLES = eac_pkg::EAC_WRITE_RC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // core side
  eac_core_if.tmr core
);
  import eac_pkg::*;

  localparam logic [EAC_TMR_W-1:0] RC_LAST = EAC_TMR_W'(RC_CYCLES - 1);
  localparam logic [3:0] DIV_LAST = 4'(EAC_RC_DIV - 1);

  logic [3:0] div_q;
  logic rc_tick;
  logic [EAC_TMR_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  // free-running divider standing in for the rc oscillator rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 4'h0;
    end else if (div_q == DIV_LAST) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign rc_tick = (div_q == DIV_LAST);

  // count rc ticks while busy; a start while busy is never issued
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (core.tmr_start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
      end else if (busy_q && rc_tick) begin
        if (cnt_q == RC_LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign core.tmr_busy = busy_q;
  assign core.tmr_done = done_q;
endmodule
`default_nettype wire

//--- logic/eac_top.sv
// Function
// [RULE1] control bits 7:4 always read back as zero
// [RULE2] ready interrupt enabled only with enable bit and global flag set
// [RULE3] ready request held high the whole time write strobe is zero
// [RULE4] strobe within four cycles of arming starts a byte write
// [RULE5] strobe without arm does nothing, no write happens
// [RULE6] arm bit self-clears four cycles after software sets it
// [RULE7] write strobe stays set during write, cleared by hardware at end
// [RULE8] software follows wait, load, arm, then strobe sequence
// [RULE9] no eeprom write starts while flash self-programming is busy
// [RULE10] software should keep global interrupts off during the sequence
// [RULE11] accepted write strobe stalls the cpu for two cycles
// [RULE12] read strobe fetches addressed byte into data register at once
// [RULE13] accepted read stalls the cpu for four cycles
// [RULE14] during a write, reads and address changes are refused
// [RULE15] software polls write strobe low before reading
// [RULE16] write lasts 27072 rc oscillator cycles before strobe clears
// [RULE17] address is 11 bits, upper five bits of high byte read zero
// [RULE18] data register feeds writes and receives read bytes
// [RULE19] strobe during an ongoing write is ignored, timing untouched
// [RULE20] re-arming restarts the four-cycle arm expiry
`timescale 1ns/1ps
`default_nettype none
module eac_top #(
  parameter int WRITE_RC_CYCLES = eac_pkg::EAC_WRITE_RC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // cpu i/o access
  input wire logic [eac_pkg::EAC_IO_ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  // cpu core status
  input wire logic global_irq_flag,
  input wire logic selfprog_busy_flag,
  output logic cpu_stall,
  output logic ready_irq
);
  import eac_pkg::*;

  localparam logic [EAC_CNT_W-1:0] ARM_LOAD = EAC_CNT_W'(EAC_ARM_CYCLES);
  localparam logic [EAC_CNT_W-1:0] WR_STALL = EAC_CNT_W'(EAC_WR_STALL_CYCLES);
  localparam logic [EAC_CNT_W-1:0] RD_STALL = EAC_CNT_W'(EAC_RD_STALL_CYCLES);

  eac_core_if core ();

  //////////////////////////////////////////////////////////////////////
  // storage and write timer
  //////////////////////////////////////////////////////////////////////

  // cell array; fetch and commit share one address port
  eac_store eac_store_inst (
    .clk(clk),
    .resetn(resetn),
    .core(core.mem)
  );

  // write duration counter on the divided rc rate
  eac_write_timer #(
    .RC_CYCLES(WRITE_RC_CYCLES)
  ) eac_write_timer_inst (
    .clk(clk),
    .resetn(resetn),
    .core(core.tmr)
  );

  //////////////////////////////////////////////////////////////////////
  // register state
  //////////////////////////////////////////////////////////////////////

  eac_wr_state_t wr_state_q;
  logic ready_irq_enable_q;
  logic master_write_arm_q;
  logic [EAC_CNT_W-1:0] arm_cnt_q;
  logic [EAC_ADDR_W-1:0] eeprom_addr_reg_q;
  logic [EAC_DATA_W-1:0] eeprom_data_reg_q;
  logic [EAC_ADDR_W-1:0] wr_addr_q;
  logic [EAC_DATA_W-1:0] wr_data_q;
  logic rd_pending_q;
  logic [EAC_CNT_W-1:0] stall_cnt_q;
  logic cpu_stall_q;
  logic ready_irq_q;
  logic [7:0] io_rdata_q;
  logic write_strobe;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic arm_set;
  logic write_start;
  logic read_start;
  logic [7:0] ctrl_view;

  // address decode of cpu writes
  assign wr_ctrl = io_we && (io_addr == EAC_OFS_CONTROL);
  assign wr_data = io_we && (io_addr == EAC_OFS_DATA);
  assign wr_addr_lo = io_we && (io_addr == EAC_OFS_ADDR_LO);
  assign wr_addr_hi = io_we && (io_addr == EAC_OFS_ADDR_HI);

  // strobe reads as one for the whole write, commit cycle included
  // [RULE7] strobe follows write state
  assign write_strobe = (wr_state_q != EAC_WR_IDLE);

  // arming takes effect only on a write that leaves the strobe bit low
  assign arm_set = wr_ctrl && io_wdata[EAC_BIT_MASTER_WRITE_ARM]
                   && !io_wdata[EAC_BIT_WRITE_STROBE];

  // [RULE4] armed strobe starts write
  // [RULE5] unarmed strobe ignored
  // [RULE9] flash programming blocks start
  // [RULE19] busy strobe ignored
  assign write_start = wr_ctrl && io_wdata[EAC_BIT_WRITE_STROBE]
                       && master_write_arm_q && !write_strobe
                       && !selfprog_busy_flag
                       && !core.tmr_busy;

  // [RULE14] no read during write
  assign read_start = wr_ctrl && io_wdata[EAC_BIT_READ_STROBE]
                      && !write_strobe;

  //////////////////////////////////////////////////////////////////////
  // control register
  //////////////////////////////////////////////////////////////////////

  // interrupt enable is a plain read/write bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_irq_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      ready_irq_enable_q <= io_wdata[EAC_BIT_READY_IRQ_ENABLE];
    end
  end

  // arm window: counts down the cycles after the arming write
  // [RULE6] arm self-clears
  // [RULE20] re-arm restarts count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      master_write_arm_q <= 1'b0;
      arm_cnt_q <= '0;
    end else if (arm_set) begin
      master_write_arm_q <= 1'b1;
      arm_cnt_q <= ARM_LOAD;
    end else if (master_write_arm_q) begin
      if (arm_cnt_q == EAC_CNT_W'(1)) begin
        master_write_arm_q <= 1'b0;
        arm_cnt_q <= '0;
      end else begin
        arm_cnt_q <= arm_cnt_q - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write sequencer
  //////////////////////////////////////////////////////////////////////

  // byte and address are latched at start, so later data writes are harmless
  // [RULE16] timed by rc ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_state_q <= EAC_WR_IDLE;
      wr_addr_q <= EAC_ADDR_RST;
      wr_data_q <= EAC_DATA_RST;
    end else begin
      case (wr_state_q)
        EAC_WR_IDLE: begin
          if (write_start) begin
            wr_state_q <= EAC_WR_BUSY;
            wr_addr_q <= eeprom_addr_reg_q;
            wr_data_q <= eeprom_data_reg_q;
          end
        end
        EAC_WR_BUSY: begin
          if (core.tmr_done) begin
            wr_state_q <= EAC_WR_COMMIT;
          end
        end
        EAC_WR_COMMIT: begin
          wr_state_q <= EAC_WR_IDLE;
        end
        default: begin
          wr_state_q <= EAC_WR_IDLE;
        end
      endcase
    end
  end

  // storage port: commit in the last cycle, fetch on an accepted read
  // [RULE18] data register feeds the write
  assign core.tmr_start = write_start;
  assign core.mem_we = (wr_state_q == EAC_WR_COMMIT);
  assign core.mem_re = read_start;
  assign core.mem_addr = write_strobe ? wr_addr_q : eeprom_addr_reg_q;
  assign core.mem_wdata = wr_data_q;

  //////////////////////////////////////////////////////////////////////
  // address and data registers
  //////////////////////////////////////////////////////////////////////

  // reset to zero only for determinism; software must still load it first
  // [RULE14] address frozen during write
  // [RULE17] 11-bit address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eeprom_addr_reg_q <= EAC_ADDR_RST;
    end else if (!write_strobe) begin
      if (wr_addr_lo) begin
        eeprom_addr_reg_q[7:0] <= io_wdata;
      end
      if (wr_addr_hi) begin
        eeprom_addr_reg_q[EAC_ADDR_W-1:8] <= io_wdata[EAC_ADDR_W-9:0];
      end
    end
  end

  // fetched byte lands two cycles after the strobe, inside the stall
  // [RULE12] read loads data register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pending_q <= 1'b0;
      eeprom_data_reg_q <= EAC_DATA_RST;
    end else begin
      rd_pending_q <= read_start;
      if (rd_pending_q) begin
        eeprom_data_reg_q <= core.mem_rdata;
      end else if (wr_data) begin
        eeprom_data_reg_q <= io_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // cpu stall
  //////////////////////////////////////////////////////////////////////

  // stall starts the cycle after the accepted strobe
  // both strobes in one write stall as a read, the longer of the two
  // [RULE11] two-cycle write stall
  // [RULE13] four-cycle read stall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_cnt_q <= '0;
      cpu_stall_q <= 1'b0;
    end else if (read_start) begin
      stall_cnt_q <= RD_STALL - 1'b1;
      cpu_stall_q <= 1'b1;
    end else if (write_start) begin
      stall_cnt_q <= WR_STALL - 1'b1;
      cpu_stall_q <= 1'b1;
    end else if (stall_cnt_q != '0) begin
      stall_cnt_q <= stall_cnt_q - 1'b1;
    end else begin
      cpu_stall_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // ready interrupt and read-back
  //////////////////////////////////////////////////////////////////////

  // level request, not a pulse, so a missed edge cannot lose it
  // [RULE2] enable and global gating
  // [RULE3] held while strobe low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_irq_q <= 1'b0;
    end else begin
      ready_irq_q <= ready_irq_enable_q && global_irq_flag && !write_strobe;
    end
  end

  // read strobe is self-clearing and reads back as zero
  // arm bit reads back so software can watch the window close
  // [RULE1] reserved bits zero
  assign ctrl_view = {EAC_CTRL_RSVD_VAL, ready_irq_enable_q, master_write_arm_q,
                      write_strobe, 1'b0};

  // registered read data; unmapped offsets answer zero
  // [RULE17] upper address bits zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_rdata_q <= 8'h00;
    end else if (io_re) begin
      case (io_addr)
        EAC_OFS_CONTROL: io_rdata_q <= ctrl_view;
        EAC_OFS_DATA: io_rdata_q <= eeprom_data_reg_q;
        EAC_OFS_ADDR_LO: io_rdata_q <= eeprom_addr_reg_q[7:0];
        EAC_OFS_ADDR_HI: io_rdata_q <= {5'h00, eeprom_addr_reg_q[EAC_ADDR_W-1:8]};
        default: io_rdata_q <= 8'h00;
      endcase
    end
  end

  assign io_rdata = io_rdata_q;
  assign cpu_stall = cpu_stall_q;
  assign ready_irq = ready_irq_q;
endmodule
`default_nettype wire

//--- dv/eac_chk.sv
`timescale 1ns/1ps
`default_nettype none
module eac_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // cpu access
  input wire logic [eac_pkg::EAC_IO_ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_rdata,
  // core status
  input wire logic global_irq_flag,
  input wire logic selfprog_busy_flag,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  import eac_pkg::*;
  logic ctl_we;
  logic [2:0] arm_q;
  assign ctl_we = io_we && (io_addr == EAC_OFS_CONTROL);
  // shadow arm window; over-estimating it only weakens the check, never false-fires
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm_q <= 3'h0;
    end else if (ctl_we && io_wdata[2:1] == 2'h2) begin
      arm_q <= 3'h4;
    end else if (arm_q != 3'h0) begin
      arm_q <= arm_q - 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_stall;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence
  sequence s_rd_stall;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence
  property p_wr_stall;
    $rose(cpu_stall) && $past(ctl_we && io_wdata[1:0] == 2'h2) |-> s_wr_stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");
  property p_rd_stall;
    $rose(cpu_stall) && $past(ctl_we && io_wdata[1:0] == 2'h1) |-> s_rd_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
  property p_no_arm;
    ctl_we && io_wdata[1:0] == 2'h2 && arm_q == 3'h0 |=> !$rose(cpu_stall);
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("strobe taken without arm");
  property p_spm;
    ctl_we && io_wdata[1:0] == 2'h2 && selfprog_busy_flag |=> !$rose(cpu_stall);
  endproperty
  a_spm: assert property (p_spm) else $error("write taken during flash busy");
  property p_rsvd;
    io_re && io_addr == EAC_OFS_CONTROL |=> io_rdata[7:4] == EAC_CTRL_RSVD_VAL;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("control high bits not zero");
  property p_addr_hi;
    io_re && io_addr == EAC_OFS_ADDR_HI |=> io_rdata[7:3] == 5'h00;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address high bits not zero");
  property p_hold;
    !io_re |=> $stable(io_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_irq_gate;
    ready_irq |-> $past(global_irq_flag);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ready request without global flag");
  property p_irq_level;
    ready_irq && global_irq_flag && !ctl_we && !$past(ctl_we) |=> ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready request dropped");
endmodule
bind eac_top eac_chk eac_chk_inst (.clk(clk), .resetn(resetn), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
  .global_irq_flag(global_irq_flag), .selfprog_busy_flag(selfprog_busy_flag),
  .cpu_stall(cpu_stall), .ready_irq(ready_irq));
`default_nettype wire

//--- dv/eac_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module eac_top_test;
  import eac_pkg::*;
  // short write count keeps the run brief
  localparam int RC = 8;
  localparam int WR_MIN = RC * EAC_RC_DIV;
  localparam int WR_MAX = WR_MIN + 12;
  localparam logic [5:0] CTL = EAC_OFS_CONTROL;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [EAC_IO_ADDR_W-1:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_we = 1'b0;
  logic io_re = 1'b0;
  logic global_irq_flag = 1'b0;
  logic selfprog_busy_flag = 1'b0;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  eac_top #(.WRITE_RC_CYCLES(RC)) eac_top_inst (.clk(clk), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata), .global_irq_flag(global_irq_flag),
    .selfprog_busy_flag(selfprog_busy_flag), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // cycle count; the ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_n(string what, int exp, int got);
    n_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // single-cycle register access, launched just after an edge
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(posedge clk);
    #1;
    io_we = 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_re = 1'b1;
    @(posedge clk);
    #1;
    io_re = 1'b0;
    d = io_rdata;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // count stall cycles following a control write
  task automatic ctl_stall(logic [7:0] d, output int n);
    wr(CTL, d);
    n = 0;
    repeat (6) begin
      if (cpu_stall === 1'b1) n++;
      @(posedge clk);
      #1;
    end
  endtask
  // poll the busy bit, bounded
  task automatic wait_idle();
    logic [7:0] c;
    c = 8'h02;
    repeat (40) begin
      if (c[1] !== 1'b0) rd(CTL, c);
    end
    cmp8("busy clear", 8'h00, c & 8'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    rd(CTL, d);
    cmp8("control", 8'h00, d);
    wr(CTL, 8'hF0);
    rd(CTL, d);
    cmp8("control rsvd", 8'h00, d);
    wr(EAC_OFS_ADDR_HI, 8'hFF);
    rd(EAC_OFS_ADDR_HI, d);
    cmp8("addr_hi", 8'h07, d);
    rd(6'h3F, d);
    cmp8("unmapped", 8'h00, d);
  endtask
  // armed write at the last legal cycle, then pokes while it runs
  task automatic t_write();
    logic [7:0] d;
    int n;
    int t0;
    wr(EAC_OFS_ADDR_LO, 8'hA5);
    wr(EAC_OFS_DATA, 8'hC3);
    wr(CTL, 8'h04);
    idle(2);
    t0 = cyc;
    ctl_stall(8'h02, n);
    cmp_n("write stall", EAC_WR_STALL_CYCLES, n);
    rd(CTL, d);
    cmp8("busy", 8'h02, d & 8'h02);
    wr(EAC_OFS_ADDR_LO, 8'h11);
    ctl_stall(8'h01, n);
    cmp_n("read in write", 0, n);
    wr(CTL, 8'h04);
    ctl_stall(8'h02, n);
    cmp_n("strobe in write", 0, n);
    wait_idle();
    n = cyc - t0;
    cmp_n("write time", 1, int'(n >= WR_MIN && n <= WR_MAX));
    rd(EAC_OFS_ADDR_LO, d);
    cmp8("addr kept", 8'hA5, d);
    ctl_stall(8'h01, n);
    cmp_n("read stall", EAC_RD_STALL_CYCLES, n);
    rd(EAC_OFS_DATA, d);
    cmp8("read byte", 8'hC3, d);
  endtask
  task automatic t_refuse();
    logic [7:0] d;
    int n;
    wr(EAC_OFS_DATA, 8'h5A);
    ctl_stall(8'h02, n);
    cmp_n("no arm", 0, n);
    wr(CTL, 8'h04);
    idle(3);
    ctl_stall(8'h02, n);
    cmp_n("arm expired", 0, n);
    wr(CTL, 8'h04);
    selfprog_busy_flag = 1'b1;
    ctl_stall(8'h02, n);
    selfprog_busy_flag = 1'b0;
    cmp_n("flash busy", 0, n);
    ctl_stall(8'h06, n);
    cmp_n("arm and strobe", 0, n);
    ctl_stall(8'h01, n);
    cmp_n("read stall old", EAC_RD_STALL_CYCLES, n);
    rd(EAC_OFS_DATA, d);
    cmp8("cell kept", 8'hC3, d);
    wr(EAC_OFS_DATA, 8'h5A);
    wr(CTL, 8'h04);
    idle(1);
    wr(CTL, 8'h04);
    idle(2);
    ctl_stall(8'h02, n);
    cmp_n("re-arm", EAC_WR_STALL_CYCLES, n);
    wait_idle();
    ctl_stall(8'h01, n);
    cmp_n("read stall new", EAC_RD_STALL_CYCLES, n);
    rd(EAC_OFS_DATA, d);
    cmp8("new byte", 8'h5A, d);
  endtask
  // ready request gated by enable and global flag, low while writing
  task automatic t_irq();
    int n;
    global_irq_flag = 1'b1;
    wr(CTL, 8'h08);
    idle(2);
    cmp8("ready on", 8'h01, {7'h00, ready_irq});
    global_irq_flag = 1'b0;
    idle(2);
    cmp8("ready gated", 8'h00, {7'h00, ready_irq});
    global_irq_flag = 1'b1;
    wr(CTL, 8'h0C);
    ctl_stall(8'h0A, n);
    cmp_n("irq write stall", EAC_WR_STALL_CYCLES, n);
    cmp8("ready busy", 8'h00, {7'h00, ready_irq});
    wait_idle();
    idle(2);
    cmp8("ready back", 8'h01, {7'h00, ready_irq});
    idle(6);
    cmp8("ready holds", 8'h01, {7'h00, ready_irq});
    wr(CTL, 8'h00);
    idle(2);
    cmp8("ready off", 8'h00, {7'h00, ready_irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_write();
    t_refuse();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
